// ### core/bae_core.sv
// Byte add and execute: decode and execute of four byte-wide ALU instructions
// Operation
// RULE1: add-to-file opcode 001001 d a f sums working register and file register
// RULE2: destination bit 0 writes result to working register, file unchanged
// RULE3: destination bit 1 writes result back to the addressed file register
// RULE4: access bit 0 uses the fixed access window, bank select ignored
// RULE5: access bit 1 forms address from bank select register and file address
// RULE6: extended set, access bit 0, address up to 95 selects indexed offset mode
// RULE7: add-with-carry adds working, file and carry; destination as plain file add
// RULE8: add-with-carry updates negative, overflow, carry, digit-carry and zero
// RULE9: and-immediate ANDs working register with literal; updates negative, zero
// RULE10: and-immediate decoded from upper byte 0000 1011
// RULE11: add-immediate decoded from upper byte 0000 1111, sum to working reg
// RULE12: one word, one cycle: decode, operand read, process, write phases
// RULE13: add-immediate and add-to-file update all five arithmetic flags
`timescale 1ns/1ps
`default_nettype none
module bae_core
    import bae_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Data memory
    output bae_mem_s         mem_req,
    input  wire logic [7:0]  mem_rdata,
    // Status
    output logic             busy
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_EXEC = 4'b0010,
        ST_DONE = 4'b0100,
        ST_ACK  = 4'b1000
    } bae_state_e;

    logic [1:0]  rst_sync_r;
    logic        rst_n;
    bae_state_e  state_r;
    bae_state_e  state_nxt;
    logic [15:0] instr_r;
    logic [7:0]  working_reg_r;
    logic [4:0]  status_r;
    logic [3:0]  bank_select_register_r;
    logic        ext_en_r;
    bae_kind_e   kind_r;
    logic [7:0]  opnd_r;
    logic [8:0]  res_r;
    logic [4:0]  flg_r;
    bae_mem_s    mem_r;
    logic [3:0]  phase;
    logic        rd_done_r;

    // Reset release through two flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    function automatic bae_kind_e decode(input logic [15:0] w);
        if (w[15:8] == BAE_OPC_ADDLIT) begin                       // [RULE11]
            return BAE_K_ADDL;
        end else if (w[15:8] == BAE_OPC_ANDLIT) begin              // [RULE10]
            return BAE_K_ANDL;
        end else if (w[15:10] == BAE_OPC_ADDF) begin               // [RULE1]
            return BAE_K_ADDF;
        end else if (w[15:10] == BAE_OPC_ADDC) begin               // [RULE7]
            return BAE_K_ADDC;
        end
        return BAE_K_NONE;
    endfunction

    // Bus decode
    wire bus_wr_instr = avs_write && avs_address == BAE_A_INSTR && state_r == ST_IDLE;
    wire bus_wr_other = avs_write && avs_address != BAE_A_INSTR;
    wire start        = bus_wr_instr;
    wire instr_wr     = avs_write && avs_address == BAE_A_INSTR;
    wire rd_first     = avs_read && !rd_done_r;

    // Instruction write stalls until the full instruction cycle completes; a read
    // stalls one cycle so the registered data stands at the edge that ends it
    assign avs_waitrequest = instr_wr ? (state_r != ST_DONE) : rd_first;
    assign busy = state_r != ST_IDLE;

    bae_phase bae_phase_inst (
        .clk   (clk),
        .rst_n (rst_n),
        .run   (start),
        .phase (phase)
    );

    // Operand address selection
    wire        acc_bit   = instr_r[BAE_POS_ACC];
    wire        dest_bit  = instr_r[BAE_POS_DEST];
    wire [7:0]  faddr     = instr_r[7:0];
    wire        is_file   = kind_r == BAE_K_ADDF || kind_r == BAE_K_ADDC;
    wire        idx_mode  = ext_en_r && !acc_bit && faddr <= BAE_IDX_LIMIT;       // [RULE6]
    // Access window: low half in bank 0, upper half in the top bank
    wire [11:0] acc_addr  = {{4{faddr[7]}}, faddr};                             // [RULE4]
    wire [11:0] bank_addr = {bank_select_register_r, faddr};                     // [RULE5]
    wire [11:0] op_addr   = acc_bit ? bank_addr : acc_addr;
    // The read leaves in the decode phase, before instr_r holds the new word,
    // so its address and mode come straight from the incoming instruction
    wire [7:0]  new_f     = avs_writedata[7:0];
    wire        new_acc   = avs_writedata[BAE_POS_ACC];
    wire [11:0] new_addr  = new_acc ? {bank_select_register_r, new_f} : {{4{new_f[7]}}, new_f};
    wire        new_idx   = ext_en_r && !new_acc && new_f <= BAE_IDX_LIMIT;         // [RULE6]
    wire [11:0] req_addr  = phase[0] ? new_addr : op_addr;
    wire        req_idx   = phase[0] ? new_idx : idx_mode;

    // Processing
    wire        cin       = (kind_r == BAE_K_ADDC) ? status_r[BAE_ST_C] : 1'b0; // [RULE7]
    wire [8:0]  sum       = {1'b0, working_reg_r} + {1'b0, opnd_r} + {8'h00, cin};
    wire [4:0]  lo_sum    = {1'b0, working_reg_r[3:0]} + {1'b0, opnd_r[3:0]} + {4'h0, cin};
    wire [7:0]  andv      = working_reg_r & opnd_r;                             // [RULE9]
    wire [7:0]  sres      = (kind_r == BAE_K_ANDL) ? andv : sum[7:0];
    wire        ovf       = (working_reg_r[7] == opnd_r[7]) && (sum[7] != working_reg_r[7]);
    wire        to_file   = is_file && dest_bit;                                // [RULE3]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: if (start) begin
                state_nxt = ST_EXEC;
            end
            ST_EXEC: if (phase[3]) begin
                state_nxt = ST_DONE;
            end
            ST_DONE: state_nxt = ST_ACK;
            ST_ACK:  state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    // Phase 1 decode, phase 2 read, phase 3 process, phase 4 write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_r <= 16'h0000;
            kind_r  <= BAE_K_NONE;
        end else if (phase[0]) begin                                           // [RULE12]
            instr_r <= avs_writedata[15:0];
            kind_r  <= decode(avs_writedata[15:0]);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            opnd_r <= 8'h00;
        end else if (phase[1]) begin                                           // [RULE12]
            opnd_r <= is_file ? mem_rdata : instr_r[7:0];                       // [RULE1]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            res_r <= 9'h000;
            flg_r <= BAE_STATUS_RST;
        end else if (phase[2]) begin                                           // [RULE12]
            res_r <= {sum[8], sres};
            flg_r[BAE_ST_C]  <= sum[8];                                         // [RULE13]
            flg_r[BAE_ST_HC] <= lo_sum[4];
            flg_r[BAE_ST_V]  <= ovf;
            flg_r[BAE_ST_Z]  <= sres == 8'h00;
            flg_r[BAE_ST_N]  <= sres[7];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            working_reg_r <= BAE_WORK_RST;
            status_r      <= BAE_STATUS_RST;
        end else if (phase[3] && kind_r != BAE_K_NONE) begin
            if (!to_file) begin
                working_reg_r <= res_r[7:0];                                     // [RULE2]
            end
            if (kind_r == BAE_K_ANDL) begin
                status_r[BAE_ST_Z] <= flg_r[BAE_ST_Z];                          // [RULE9]
                status_r[BAE_ST_N] <= flg_r[BAE_ST_N];
            end else begin
                status_r <= flg_r;                                              // [RULE8]
            end
        end else if (bus_wr_other && avs_address == BAE_A_WORK) begin
            working_reg_r <= avs_writedata[7:0];
        end else if (bus_wr_other && avs_address == BAE_A_STATUS) begin
            status_r <= avs_writedata[4:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bank_select_register_r <= BAE_BANK_RST;
            ext_en_r               <= 1'b0;
        end else if (bus_wr_other && avs_address == BAE_A_CTRL) begin
            bank_select_register_r <= avs_writedata[3:0];
            ext_en_r               <= avs_writedata[BAE_CTRL_EXT];
        end
    end

    // Memory request: read in phase 2, write in phase 4
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_r <= '0;
        end else begin
            mem_r.rd      <= phase[0] && (decode(avs_writedata[15:0]) == BAE_K_ADDF
                             || decode(avs_writedata[15:0]) == BAE_K_ADDC);
            mem_r.wr      <= phase[2] && to_file;                               // [RULE3]
            mem_r.addr    <= req_addr;
            mem_r.indexed <= req_idx;                                           // [RULE6]
            mem_r.wdata   <= sres;
        end
    end
    assign mem_req = mem_r;

    // Read data: loaded in the stalled first cycle, held through the releasing edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
            rd_done_r    <= 1'b0;
        end else begin
            rd_done_r <= rd_first;
            if (rd_first) begin
                case (avs_address)
                    BAE_A_INSTR:  avs_readdata <= {16'h0000, instr_r};
                    BAE_A_WORK:   avs_readdata <= {24'h000000, working_reg_r};
                    BAE_A_STATUS: avs_readdata <= {27'h0000000, status_r};
                    BAE_A_CTRL:   avs_readdata <= {27'h0000000, ext_en_r, bank_select_register_r};
                    default:      avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Assertions
    property p_work_kept;
        @(posedge clk) disable iff (!rst_n)
        (phase[3] && to_file) |=> $stable(working_reg_r);
    endproperty
    a_work_kept: assert property (p_work_kept) else $error("file dest changed w"); // [RULE2]

    property p_file_write;
        @(posedge clk) disable iff (!rst_n)
        (phase[2] && to_file) |=> mem_r.wr && mem_r.wdata == res_r[7:0];
    endproperty
    a_file_write: assert property (p_file_write) else $error("no file write"); // [RULE3]

    property p_phase_seq;
        @(posedge clk) disable iff (!rst_n)
        phase[0] |=> phase[1] ##1 phase[2] ##1 phase[3];
    endproperty
    a_phase_seq: assert property (p_phase_seq) else $error("bad phase order"); // [RULE12]

    property p_bank;
        @(posedge clk) disable iff (!rst_n)
        acc_bit |-> op_addr[11:8] == bank_select_register_r;
    endproperty
    a_bank: assert property (p_bank) else $error("bank not used"); // [RULE5]

    property p_access;
        @(posedge clk) disable iff (!rst_n)
        (!acc_bit && !faddr[7]) |-> op_addr[11:8] == 4'h0;
    endproperty
    a_access: assert property (p_access) else $error("access window wrong"); // [RULE4]

    property p_idx;
        @(posedge clk) disable iff (!rst_n)
        (ext_en_r && !acc_bit && faddr == 8'h60) |-> !idx_mode;
    endproperty
    a_idx: assert property (p_idx) else $error("indexed limit wrong"); // [RULE6]

    property p_and_work;
        @(posedge clk) disable iff (!rst_n)
        (phase[3] && kind_r == BAE_K_ANDL) |=> working_reg_r == res_r[7:0]
            && status_r[BAE_ST_C] == $past(status_r[BAE_ST_C]);
    endproperty
    a_and_work: assert property (p_and_work) else $error("and result wrong"); // [RULE9]

    property p_carry_in;
        @(posedge clk) disable iff (!rst_n)
        (phase[2] && kind_r == BAE_K_ADDC) |=>
            res_r == 9'($past(working_reg_r)) + 9'($past(opnd_r)) + 9'($past(status_r[BAE_ST_C]));
    endproperty
    a_carry_in: assert property (p_carry_in) else $error("carry add wrong"); // [RULE7]

    property p_flags;
        @(posedge clk) disable iff (!rst_n)
        (phase[3] && (kind_r == BAE_K_ADDF || kind_r == BAE_K_ADDL)) |=> status_r == $past(flg_r);
    endproperty
    a_flags: assert property (p_flags) else $error("flags not updated"); // [RULE13]
endmodule
`default_nettype wire

// ### core/bae_phase.sv
// Phase generator: four one-cycle phase strobes per instruction cycle
`timescale 1ns/1ps
`default_nettype none
module bae_phase
    import bae_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Control
    input  wire logic       run,
    // Phase strobes
    output logic [3:0]      phase
);
    logic [1:0] cnt_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 2'h0;
        end else if (run || cnt_r != 2'h0) begin
            cnt_r <= cnt_r + 2'h1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < BAE_PHASES; g++) begin : g_ph
            assign phase[g] = (cnt_r == 2'(g)) && (run || cnt_r != 2'h0);
        end
    endgenerate
endmodule
`default_nettype wire

// ### core/bae_pkg.sv
// Package: constants and carrier types for the byte add and execute block
package bae_pkg;

    // Opcode fields
    localparam logic [5:0] BAE_OPC_ADDF   = 6'h09;
    localparam logic [5:0] BAE_OPC_ADDC   = 6'h08;
    localparam logic [7:0] BAE_OPC_ADDLIT = 8'h0f;
    localparam logic [7:0] BAE_OPC_ANDLIT = 8'h0b;
    localparam int         BAE_POS_DEST   = 9;
    localparam int         BAE_POS_ACC    = 8;
    localparam logic [7:0] BAE_IDX_LIMIT  = 8'h5f;

    // Status register bit positions
    localparam int BAE_ST_C  = 0;
    localparam int BAE_ST_HC = 1;
    localparam int BAE_ST_Z  = 2;
    localparam int BAE_ST_V  = 3;
    localparam int BAE_ST_N  = 4;

    // Reset values
    localparam logic [7:0] BAE_WORK_RST   = 8'h00;
    localparam logic [4:0] BAE_STATUS_RST = 5'h00;
    localparam logic [3:0] BAE_BANK_RST   = 4'h0;

    // Phases per instruction cycle
    localparam int         BAE_PHASES     = 4;

    // Register bus map (word-aligned byte addresses)
    localparam logic [3:0] BAE_A_INSTR  = 4'h0;
    localparam logic [3:0] BAE_A_WORK   = 4'h4;
    localparam logic [3:0] BAE_A_STATUS = 4'h8;
    localparam logic [3:0] BAE_A_CTRL   = 4'hc;
    localparam int         BAE_CTRL_EXT = 4;

    // Decoded instruction kinds
    typedef enum logic [4:0] {
        BAE_K_NONE = 5'b00001,
        BAE_K_ADDL = 5'b00010,
        BAE_K_ADDF = 5'b00100,
        BAE_K_ADDC = 5'b01000,
        BAE_K_ANDL = 5'b10000
    } bae_kind_e;

    // Data memory request
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [11:0] addr;
        logic       indexed;
        logic [7:0] wdata;
    } bae_mem_s;

endpackage

// ### tb/bae_dmem_model.sv
// Data memory model facing the core's data port
`timescale 1ns/1ps
`default_nettype none
module bae_dmem_model
    import bae_pkg::*;
(
    // Clock
    input  wire logic     clk,
    // Core data port
    input  wire bae_mem_s mem_req,
    output logic [7:0]    mem_rdata
);
    logic [7:0] mem [0:4095];
    logic       last_idx = 1'b0;
    int         wr_cnt   = 0;
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'h00;
        end
    end
    // Read answers in the cycle the request stands; off-cycle data is
    // inverted so a sample outside that cycle never matches by luck
    assign mem_rdata = mem_req.rd ? mem[mem_req.addr] : ~mem[mem_req.addr];
    always @(posedge clk) begin
        if (mem_req.rd) begin
            last_idx <= mem_req.indexed;
        end
        if (mem_req.wr) begin
            mem[mem_req.addr] <= mem_req.wdata;
            wr_cnt            <= wr_cnt + 1;
        end
    end
endmodule
`default_nettype wire

// ### tb/test_byte_add_and_execute.sv
// Testbench for the byte add and execute core
`timescale 1ns/1ps
`default_nettype none
module test_byte_add_and_execute
    import bae_pkg::*;
;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    bae_mem_s    mem_req;
    logic [7:0]  mem_rdata;
    logic        busy;
    int          err_count = 0;
    int          num_checks = 0;
    int          n;
    logic [31:0] d;

    bae_core bae_core_inst (.clk(clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .mem_req(mem_req), .mem_rdata(mem_rdata), .busy(busy));
    bae_dmem_model bae_dmem_model_inst (.clk(clk), .mem_req(mem_req),
        .mem_rdata(mem_rdata));

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic final_report();
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Waitrequest is combinational, so it is read settled at the falling edge
    task automatic wait_ack();
        logic w;
        n = 0;
        do begin
            @(negedge clk);
            w = avs_waitrequest;
            d = avs_readdata;
            @(posedge clk);
            n++;
        end while (w !== 1'b0 && n < 50);
        if (w !== 1'b0) begin
            err_count++;
            $display("[FAIL] t=%0t waitrequest got=%h exp=%h", $time, w, 1'b0);
        end
    endtask

    task automatic av_wr(input logic [3:0] a, input logic [31:0] v);
        avs_address   <= a;
        avs_writedata <= v;
        avs_write     <= 1'b1;
        wait_ack();
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    // Read data is taken with waitrequest, as it stands at the releasing edge
    task automatic av_rd(input logic [3:0] a, input logic [31:0] exp);
        avs_address <= a;
        avs_read    <= 1'b1;
        wait_ack();
        avs_read <= 1'b0;
        @(posedge clk);
        chk(d, exp);
    endtask

    task automatic exec(input logic [15:0] ins);
        av_wr(BAE_A_INSTR, {16'h0, ins});
        chk(32'(n >= 1 && n <= BAE_PHASES + 1), 32'h1);
        @(negedge clk);
        chk({31'h0, busy}, 32'h0);
        @(posedge clk);
    endtask

    task automatic setw(input logic [7:0] w, input logic [7:0] st);
        av_wr(BAE_A_WORK, {24'h0, w});
        av_wr(BAE_A_STATUS, {24'h0, 3'h0, st[4:0]});
    endtask

    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        av_rd(BAE_A_WORK, {24'h0, BAE_WORK_RST});
        av_rd(BAE_A_STATUS, {27'h0, BAE_STATUS_RST});
        av_rd(4'h2, 32'h0);
        setw(8'h10, 5'h1f);
        exec(16'h0f15);
        av_rd(BAE_A_WORK, 32'h25);
        av_rd(BAE_A_STATUS, 32'h00);
        setw(8'hff, 5'h00);
        exec(16'h0f01);
        av_rd(BAE_A_STATUS, 32'h07);
        setw(8'ha3, 5'h1f);
        exec(16'h0b5f);
        av_rd(BAE_A_WORK, 32'h03);
        av_rd(BAE_A_STATUS, 32'h0b);
        // Direct window access with bank 3 selected must stay in bank 0
        av_wr(BAE_A_CTRL, 32'h03);
        bae_dmem_model_inst.mem[12'h020] = 8'hc2;
        setw(8'h17, 5'h00);
        exec(16'h2420);
        av_rd(BAE_A_WORK, 32'hd9);
        av_rd(BAE_A_STATUS, 32'h10);
        chk(32'(bae_dmem_model_inst.wr_cnt), 32'h0);
        bae_dmem_model_inst.mem[12'h340] = 8'h70;
        setw(8'h10, 5'h00);
        exec(16'h2740);
        chk({24'h0, bae_dmem_model_inst.mem[12'h340]}, 32'h80);
        av_rd(BAE_A_WORK, 32'h10);
        av_rd(BAE_A_STATUS, 32'h18);
        av_wr(BAE_A_CTRL, 32'h02);
        bae_dmem_model_inst.mem[12'h210] = 8'h4d;
        setw(8'h02, 5'h01);
        exec(16'h2110);
        av_rd(BAE_A_WORK, 32'h50);
        av_rd(BAE_A_STATUS, 32'h02);
        av_wr(BAE_A_CTRL, 32'h05);
        bae_dmem_model_inst.mem[12'hf90] = 8'h01;
        setw(8'h05, 5'h00);
        exec(16'h2690);
        chk({24'h0, bae_dmem_model_inst.mem[12'hf90]}, 32'h06);
        // Indexed mode only up to the limit, only with the extended set
        exec(16'h245f);
        chk({31'h0, bae_dmem_model_inst.last_idx}, 32'h0);
        av_wr(BAE_A_CTRL, 32'h10);
        exec(16'h245f);
        chk({31'h0, bae_dmem_model_inst.last_idx}, 32'h1);
        exec(16'h2460);
        chk({31'h0, bae_dmem_model_inst.last_idx}, 32'h0);
        exec(16'h255f);
        chk({31'h0, bae_dmem_model_inst.last_idx}, 32'h0);
        final_report();
    end

    // Whole sequence needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        final_report();
    end
endmodule
`default_nettype wire
